// file: xrpc_regs.sv
// Extended register bank: SRAM window, power control and address stack.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// What this block does
// RL1: Host sets bank select in register A before touching these registers.
// RL2: SRAM address is low byte at 50h, upper bits right-justified at 51h.
// RL3: Reading or writing 53h accesses the SRAM byte at the held address.
// RL4: With burst enabled, address increments on strobe rise for 53h only.
// RL5: SRAM stays write-protected until power good releases it.
// RL6: Reserved bit 4 stores and reads back, with no effect.
// RL7: Update flag sets 122 us ahead of update, clears when update ends.
// RL8: Power output release low drives power pin low, high floats it.
// RL9: Enabled wake or kick flag clears power output release to zero.
// RL10: RAM clear flag sets on clear input fall when enabled; writable.
// RL11: Wake flag set by alarm or write of one, cleared by write zero.
// RL12: Kick flag set by kick input falling or write one; write zero clears.
// RL13: Writing aux battery enable one enables the auxiliary supply pin.
// RL14: Oscillator enable routes 32 kHz to square wave; forced on power-up.
// RL15: Crystal load select picks 6 pF at zero, 12.5 pF at one.
// RL16: Clear enable lets a low clear input wipe user RAM; else ignored.
// RL17: On power fail the power pin floats unless keep bit is one.
// RL18: Clear interrupt enable drives interrupt pin low after a RAM clear.
// RL19: Enabled wake flag drives power pin, and interrupt pin with power.
// RL20: Enabled kick flag drives power pin, and interrupt pin with power.
// RL21: Each address latch fall pushes a four-deep stack read at 4Eh, 4Fh.
// RL22: Wake flag sets when date and time match the alarm settings.
// RL23: Stack reads leave entries untouched; writes to them are ignored.
////////////////////////////////////////////////////////////////////////////

module xrpc_regs
  import xrpc_pkg::*;
#(
  parameter int UIP_LEAD_CYCLES = XRPC_UIP_LEAD_CYC
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  ad_in,
  output logic      [7:0]  ad_out,
  output logic             ad_oe,
  input  wire logic        ale,
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        bank_select_bit,
  input  wire logic        power_good_signal,
  input  wire logic        vcc_present,
  input  wire logic        aux_battery_valid,
  input  wire logic        update_due,
  input  wire logic        update_done,
  output logic             update_start,
  input  wire logic [31:0] time_now,
  input  wire logic [31:0] alarm_setting,
  input  wire logic        kick_input_pin_n,
  input  wire logic        ram_clear_input_n,
  output logic             user_ram_clear,
  input  wire logic        osc_32k,
  output logic             square_wave_pin,
  output logic             aux_battery_enable,
  output logic             crystal_load_select,
  output logic             power_on_request_pin_n_out,
  output logic             power_on_request_pin_n_oe,
  output logic             interrupt_request_pin_n_out,
  output logic             interrupt_request_pin_n_oe
);

  ////////////////////////////////////////////////////////////////////////
  // Strobe and pin edge detection.

  logic ale_fall;
  logic rd_rise;
  logic wr_rise;
  logic kick_fall;
  logic ram_clear_input_fall;
  logic vcc_rise;
  logic vcc_fall;
  logic match_rise;
  logic alarm_match;

  assign alarm_match = (time_now == alarm_setting);

  xrpc_edge #(.IDLE_LEVEL(1'b0)) u_ale_edge (
    .clk   (clk),
    .rstn  (rstn),
    .level (ale),
    .rise  (),
    .fall  (ale_fall)
  );

  xrpc_edge #(.IDLE_LEVEL(1'b1)) u_rd_edge (
    .clk   (clk),
    .rstn  (rstn),
    .level (rd_n),
    .rise  (rd_rise),
    .fall  ()
  );

  xrpc_edge #(.IDLE_LEVEL(1'b1)) u_wr_edge (
    .clk   (clk),
    .rstn  (rstn),
    .level (wr_n),
    .rise  (wr_rise),
    .fall  ()
  );

  xrpc_edge #(.IDLE_LEVEL(1'b1)) u_kick_edge (
    .clk   (clk),
    .rstn  (rstn),
    .level (kick_input_pin_n),
    .rise  (),
    .fall  (kick_fall)
  );

  xrpc_edge #(.IDLE_LEVEL(1'b1)) u_ram_clear_input_edge (
    .clk   (clk),
    .rstn  (rstn),
    .level (ram_clear_input_n),
    .rise  (),
    .fall  (ram_clear_input_fall)
  );

  // The idle level of one means a block reset with power up is no power-up.
  xrpc_edge #(.IDLE_LEVEL(1'b1)) u_vcc_edge (
    .clk   (clk),
    .rstn  (rstn),
    .level (vcc_present),
    .rise  (vcc_rise),
    .fall  (vcc_fall)
  );

  // Only the start of a match counts, so a cleared flag stays cleared.
  xrpc_edge #(.IDLE_LEVEL(1'b0)) u_match_edge (
    .clk   (clk),
    .rstn  (rstn),
    .level (alarm_match),
    .rise  (match_rise),
    .fall  ()
  );

  ////////////////////////////////////////////////////////////////////////
  // Address stack and access decode.

  logic [7:0] stack_cur;
  logic [7:0] stack_prev1;
  logic [7:0] stack_prev2;
  logic [7:0] stack_prev3;

  // Every latch pushes, whatever the address, so an interrupted access
  // can be recovered even after the bank is switched.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stack_cur   <= XRPC_RST_STACK;
      stack_prev1 <= XRPC_RST_STACK;
      stack_prev2 <= XRPC_RST_STACK;
      stack_prev3 <= XRPC_RST_STACK;
    end else if (ale_fall) begin // [RL21]
      stack_cur   <= ad_in;
      stack_prev1 <= stack_cur;
      stack_prev2 <= stack_prev1;
      stack_prev3 <= stack_prev2;
    end
  end

  logic sel;
  logic wr_hit;
  logic rd_hit;
  logic mapped;

  // The bank select bit lives in register A, outside this block.
  assign sel    = ~cs_n & bank_select_bit; // [RL1]
  assign wr_hit = sel & wr_rise;
  assign rd_hit = sel & rd_rise;
  assign mapped = (stack_cur == XRPC_OFS_CTRL_A)
                | (stack_cur == XRPC_OFS_CTRL_B)
                | (stack_cur == XRPC_OFS_STACK_OLDER)
                | (stack_cur == XRPC_OFS_STACK_NEWER)
                | (stack_cur == XRPC_OFS_XRAM_LOW)
                | (stack_cur == XRPC_OFS_XRAM_HIGH)
                | (stack_cur == XRPC_OFS_XRAM_DATA);

  logic wr_a;
  logic wr_b;
  logic wr_lo;
  logic wr_hi;
  logic wr_data;
  logic rd_data;

  assign wr_a    = wr_hit & (stack_cur == XRPC_OFS_CTRL_A);
  assign wr_b    = wr_hit & (stack_cur == XRPC_OFS_CTRL_B);
  assign wr_lo   = wr_hit & (stack_cur == XRPC_OFS_XRAM_LOW);
  assign wr_hi   = wr_hit & (stack_cur == XRPC_OFS_XRAM_HIGH);
  assign wr_data = wr_hit & (stack_cur == XRPC_OFS_XRAM_DATA);
  assign rd_data = rd_hit & (stack_cur == XRPC_OFS_XRAM_DATA);

  ////////////////////////////////////////////////////////////////////////
  // Extended SRAM and its address pointer.

  logic [XRPC_XRAM_AW-1:0] xram_addr;
  logic [7:0]              xram [0:XRPC_XRAM_BYTES-1];
  logic                    burst_increment_enable;

  // Address registers; burst steps after the access at the strobe rise.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      xram_addr <= '0;
    end else if (wr_lo) begin // [RL2]
      xram_addr[7:0] <= ad_in;
    end else if (wr_hi) begin // [RL2]
      xram_addr[XRPC_XRAM_AW-1:8] <= ad_in[XRPC_XRAM_HI_W-1:0];
    end else if ((wr_data | rd_data) & burst_increment_enable) begin // [RL4]
      xram_addr <= xram_addr + {{(XRPC_XRAM_AW-1){1'b0}}, 1'b1};
    end
  end

  // Storage only; writes are dropped while power good is absent.
  always_ff @(posedge clk) begin
    if (wr_data & power_good_signal) begin // [RL3] [RL5]
      xram[xram_addr] <= ad_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // First extended control register.

  logic rsvd;
  logic power_output_release;
  logic rf;
  logic wf;
  logic kf;
  logic abe;
  logic osc_output_enable;
  logic cs_sel;
  logic ram_clear_enable;
  logic power_fail_output_keep;
  logic ram_clear_irq_enable;
  logic wake_alarm_irq_enable;
  logic kick_irq_enable;
  logic uip_flag;
  logic pab_clear;

  // Plain storage bits.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      burst_increment_enable  <= 1'b0;
      rsvd <= 1'b0;
    end else if (wr_a) begin
      burst_increment_enable  <= ad_in[XRPC_A_BME]; // [RL4]
      rsvd <= ad_in[XRPC_A_RSVD]; // [RL6]
    end
  end

  assign pab_clear = (wf & wake_alarm_irq_enable) | (kf & kick_irq_enable);

  // Auto-clear beats a host write of one, so an enabled event can never
  // be lost by software racing to power down.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      power_output_release <= XRPC_RST_PAB;
    end else if (pab_clear) begin // [RL9]
      power_output_release <= 1'b0;
    end else if (wr_a) begin // [RL8]
      power_output_release <= ad_in[XRPC_A_PAB];
    end else if (vcc_fall & ~power_fail_output_keep) begin // [RL17]
      power_output_release <= 1'b1;
    end
  end

  // Event flags: a set arriving with a host clear wins.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rf <= 1'b0;
      wf <= 1'b0;
      kf <= 1'b0;
    end else begin
      rf <= (ram_clear_input_fall & ram_clear_enable) | (wr_a ? ad_in[XRPC_A_RF] : rf); // [RL10]
      wf <= match_rise | (wr_a ? ad_in[XRPC_A_WF] : wf); // [RL11] [RL22]
      kf <= kick_fall | (wr_a ? ad_in[XRPC_A_KF] : kf); // [RL12]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Second extended control register.

  // A power-up forces the oscillator output on over any write.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {abe, osc_output_enable, cs_sel, ram_clear_enable, power_fail_output_keep, ram_clear_irq_enable, wake_alarm_irq_enable, kick_irq_enable} <= XRPC_RST_CTRL_B;
    end else begin
      if (wr_b) begin
        abe    <= ad_in[XRPC_B_ABE]; // [RL13]
        cs_sel <= ad_in[XRPC_B_CS]; // [RL15]
        ram_clear_enable    <= ad_in[XRPC_B_RCE];
        power_fail_output_keep    <= ad_in[XRPC_B_PRS];
        ram_clear_irq_enable    <= ad_in[XRPC_B_RIE];
        wake_alarm_irq_enable    <= ad_in[XRPC_B_WIE];
        kick_irq_enable    <= ad_in[XRPC_B_KSE];
      end
      if (vcc_rise) begin // [RL14]
        osc_output_enable <= XRPC_RST_OSC_OUTPUT_ENABLE;
      end else if (wr_b) begin
        osc_output_enable <= ad_in[XRPC_B_OSC_OUTPUT_ENABLE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Update-in-progress sequencer.

  xrpc_uip_state_t            uip_state;
  logic [XRPC_UIP_CNT_W-1:0]  uip_cnt;

  // The lead counter holds off the update start for the set lead time.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      uip_state    <= XRPC_UIP_IDLE;
      uip_cnt      <= '0;
      update_start <= 1'b0;
    end else begin
      update_start <= 1'b0;
      case (uip_state)
        XRPC_UIP_IDLE: begin
          uip_cnt <= '0;
          if (update_due) begin // [RL7]
            uip_state <= XRPC_UIP_LEAD;
          end
        end
        XRPC_UIP_LEAD: begin
          if (uip_cnt == XRPC_UIP_CNT_W'(UIP_LEAD_CYCLES - 1)) begin // [RL7]
            uip_state    <= XRPC_UIP_BUSY;
            update_start <= 1'b1;
          end else begin
            uip_cnt <= uip_cnt + {{(XRPC_UIP_CNT_W-1){1'b0}}, 1'b1};
          end
        end
        XRPC_UIP_BUSY: begin
          if (update_done) begin // [RL7]
            uip_state <= XRPC_UIP_IDLE;
          end
        end
        default: begin
          uip_state <= XRPC_UIP_IDLE;
        end
      endcase
    end
  end

  assign uip_flag = (uip_state != XRPC_UIP_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // Read path onto the multiplexed bus.

  // Read data is sampled every cycle, strobe low or not; stack reads only
  // look at the entries and never pop them.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ad_out <= 8'h00;
      ad_oe  <= 1'b0;
    end else begin
      ad_oe <= sel & ~rd_n & mapped;
      case (stack_cur)
        XRPC_OFS_CTRL_A:
          ad_out <= {aux_battery_valid, uip_flag, burst_increment_enable, rsvd,
                     power_output_release, rf, wf, kf}; // [RL6]
        XRPC_OFS_CTRL_B:
          ad_out <= {abe, osc_output_enable, cs_sel, ram_clear_enable, power_fail_output_keep, ram_clear_irq_enable, wake_alarm_irq_enable, kick_irq_enable};
        XRPC_OFS_STACK_OLDER: ad_out <= stack_prev2; // [RL21] [RL23]
        XRPC_OFS_STACK_NEWER: ad_out <= stack_prev1; // [RL21] [RL23]
        XRPC_OFS_XRAM_LOW:    ad_out <= xram_addr[7:0];
        XRPC_OFS_XRAM_HIGH:
          ad_out <= {{(16-XRPC_XRAM_AW){1'b0}},
                     xram_addr[XRPC_XRAM_AW-1:8]}; // [RL2]
        XRPC_OFS_XRAM_DATA:   ad_out <= xram[xram_addr]; // [RL3]
        default:              ad_out <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pins: power request, interrupt, square wave, RAM clear, options.

  logic irq_cond;

  // Wake and kick reach the interrupt pin only with main power present.
  assign irq_cond = (rf & ram_clear_irq_enable)
                  | (vcc_present & wf & wake_alarm_irq_enable)
                  | (vcc_present & kf & kick_irq_enable); // [RL18] [RL19] [RL20]

  // Pins are registered; the wire level is low whenever enable is high.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      power_on_request_pin_n_out  <= 1'b0;
      power_on_request_pin_n_oe   <= 1'b0;
      interrupt_request_pin_n_out <= 1'b0;
      interrupt_request_pin_n_oe  <= 1'b0;
    end else begin
      power_on_request_pin_n_out  <= 1'b0;
      power_on_request_pin_n_oe   <= ~power_output_release | pab_clear; // [RL8] [RL19] [RL20]
      interrupt_request_pin_n_out <= 1'b0;
      interrupt_request_pin_n_oe  <= irq_cond; // [RL18]
    end
  end

  // Option outputs and the level that runs the user RAM wipe.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      square_wave_pin     <= 1'b0;
      aux_battery_enable  <= 1'b0;
      crystal_load_select <= 1'b0;
      user_ram_clear      <= 1'b0;
    end else begin
      square_wave_pin     <= osc_output_enable & osc_32k; // [RL14]
      aux_battery_enable  <= abe; // [RL13]
      crystal_load_select <= cs_sel; // [RL15]
      user_ram_clear      <= ram_clear_enable & ~ram_clear_input_n; // [RL16]
    end
  end

endmodule

`default_nettype wire

// file: xrpc_pkg.sv
// Constants shared by the extended register and power control block.
package xrpc_pkg;

  // Register offsets inside the second register bank.
  localparam logic [7:0] XRPC_OFS_CTRL_A      = 8'h4a;
  localparam logic [7:0] XRPC_OFS_CTRL_B      = 8'h4b;
  localparam logic [7:0] XRPC_OFS_STACK_OLDER = 8'h4e;
  localparam logic [7:0] XRPC_OFS_STACK_NEWER = 8'h4f;
  localparam logic [7:0] XRPC_OFS_XRAM_LOW    = 8'h50;
  localparam logic [7:0] XRPC_OFS_XRAM_HIGH   = 8'h51;
  localparam logic [7:0] XRPC_OFS_XRAM_DATA   = 8'h53;

  // Field positions of the first extended control register.
  localparam int XRPC_A_AUX_VALID = 7;
  localparam int XRPC_A_UIP       = 6;
  localparam int XRPC_A_BME       = 5;
  localparam int XRPC_A_RSVD      = 4;
  localparam int XRPC_A_PAB       = 3;
  localparam int XRPC_A_RF        = 2;
  localparam int XRPC_A_WF        = 1;
  localparam int XRPC_A_KF        = 0;

  // Field positions of the second extended control register.
  localparam int XRPC_B_ABE  = 7;
  localparam int XRPC_B_OSC_OUTPUT_ENABLE = 6;
  localparam int XRPC_B_CS   = 5;
  localparam int XRPC_B_RCE  = 4;
  localparam int XRPC_B_PRS  = 3;
  localparam int XRPC_B_RIE  = 2;
  localparam int XRPC_B_WIE  = 1;
  localparam int XRPC_B_KSE  = 0;

  // Extended SRAM geometry: 8k bytes, low byte plus five upper bits.
  localparam int XRPC_XRAM_AW    = 13;
  localparam int XRPC_XRAM_HI_W  = 5;
  localparam int XRPC_XRAM_BYTES = 8192;

  // Reset values of the control fields.
  localparam logic       XRPC_RST_PAB     = 1'b0;
  localparam logic       XRPC_RST_OSC_OUTPUT_ENABLE    = 1'b1;
  localparam logic [7:0] XRPC_RST_CTRL_B  = 8'h40;
  localparam logic [7:0] XRPC_RST_STACK   = 8'h00;

  // Lead time of the update flag ahead of the update cycle.
  localparam int XRPC_CLK_MHZ       = 200;
  localparam int XRPC_UIP_LEAD_US   = 122;
  localparam int XRPC_UIP_LEAD_CYC  = XRPC_UIP_LEAD_US * XRPC_CLK_MHZ;
  localparam int XRPC_UIP_CNT_W     = 15;

  // Update flag sequencer states.
  typedef enum logic [1:0] {
    XRPC_UIP_IDLE,
    XRPC_UIP_LEAD,
    XRPC_UIP_BUSY
  } xrpc_uip_state_t;

endpackage

// file: xrpc_edge.sv
// Edge detector for one synchronous level.
`timescale 1ns/1ps
`default_nettype none

module xrpc_edge #(
  parameter logic IDLE_LEVEL = 1'b1
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);

  logic prev;

  // Previous sample; the idle level avoids a false edge after reset.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev <= IDLE_LEVEL;
    end else begin
      prev <= level;
    end
  end

  // One-cycle pulses on each transition.
  assign rise = level & ~prev;
  assign fall = ~level & prev;

endmodule

`default_nettype wire

// file: xrpc_regs_sva.sv
// Port-level checks for the extended register bank.
`timescale 1ns/1ps
`default_nettype none

module xrpc_regs_sva
  import xrpc_pkg::*;
#(
  parameter int UIP_LEAD_CYCLES = XRPC_UIP_LEAD_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ad_oe,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic update_due,
  input wire logic update_start,
  input wire logic ram_clear_input_n,
  input wire logic user_ram_clear,
  input wire logic osc_32k,
  input wire logic square_wave_pin,
  input wire logic aux_battery_enable,
  input wire logic crystal_load_select,
  input wire logic power_on_request_pin_n_out,
  input wire logic interrupt_request_pin_n_out
);
  logic [7:0] since_due;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Cycles since the last update request; saturates so it never wraps.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      since_due <= 8'hff;
    end else if (update_due) begin
      since_due <= 8'h00;
    end else if (since_due != 8'hff) begin
      since_due <= since_due + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////
  read_cause_a: assert property (ad_oe |->
    !$past(rd_n) || !$past(rd_n, 2))
    else $error("bus driven without a read strobe");
  rd_release_a: assert property ($rose(rd_n) |-> ##2 !ad_oe)
    else $error("bus still driven after read ended");
  unsel_quiet_a: assert property (cs_n [*3] |-> !ad_oe)
    else $error("bus driven while not selected");
  uip_window_a: assert property (update_start |->
    int'(since_due) inside {[UIP_LEAD_CYCLES - 2:UIP_LEAD_CYCLES + 2]})
    else $error("update start off its lead time");
  start_pulse_a: assert property (update_start |=> !update_start)
    else $error("update start longer than one cycle");
  pins_low_a: assert property (power_on_request_pin_n_out == 1'b0
    && interrupt_request_pin_n_out == 1'b0)
    else $error("open drain pin drives high");
  clear_cause_a: assert property (user_ram_clear |->
    !$past(ram_clear_input_n))
    else $error("user RAM clear without a low clear input");
  sqw_cause_a: assert property (square_wave_pin |-> $past(osc_32k))
    else $error("square wave high without oscillator");
  cfg_by_write_a: assert property (
    $changed(aux_battery_enable) || $changed(crystal_load_select) |->
    !$past(wr_n, 2) || !$past(wr_n, 3) || !$past(wr_n, 4))
    else $error("config output changed without a write");

  cover property (update_start);
  cover property (user_ram_clear);
  cover property ($rose(aux_battery_enable));
  cover property ($fell(ad_oe));
endmodule

bind xrpc_regs xrpc_regs_sva #(.UIP_LEAD_CYCLES(UIP_LEAD_CYCLES)) xrpc_sva_inst (
  .clk(clk), .rstn(rstn), .ad_oe(ad_oe), .cs_n(cs_n), .rd_n(rd_n),
  .wr_n(wr_n), .update_due(update_due), .update_start(update_start),
  .ram_clear_input_n(ram_clear_input_n), .user_ram_clear(user_ram_clear),
  .osc_32k(osc_32k), .square_wave_pin(square_wave_pin),
  .aux_battery_enable(aux_battery_enable),
  .crystal_load_select(crystal_load_select),
  .power_on_request_pin_n_out(power_on_request_pin_n_out),
  .interrupt_request_pin_n_out(interrupt_request_pin_n_out)
);
`default_nettype wire

// file: xrpc_host.sv
// Host processor model for the multiplexed address and data bus.
`timescale 1ns/1ps
`default_nettype none

module xrpc_host (
  input  wire logic       clk,
  input  wire logic [7:0] ad_out,
  input  wire logic       ad_oe,
  output logic      [7:0] ad_in,
  output logic            ale,
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic            bank_select_bit
);
  // Idle bus; the second bank is selected before any access.
  initial begin
    ad_in = 8'h00;
    ale = 1'b0;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    bank_select_bit = 1'b1;
  end

  ////////////////////////////////////////////////////////////
  // One access: latch, one strobe cycle, then release.
  // A released bus shows the inverse of its last value, not a hold.
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] q,
                     output logic oe);
    @(posedge clk) #1;
    cs_n = 1'b0;
    ale = 1'b1;
    ad_in = a;
    @(posedge clk) #1;
    ale = 1'b0;  // Address stands until the edge that sees the fall.
    @(posedge clk) #1;
    ad_in = w ? d : ~a;
    wr_n = !w;
    rd_n = w;
    @(posedge clk) #1;
    q = ad_out;
    oe = ad_oe;
    wr_n = 1'b1;
    rd_n = 1'b1;
    @(posedge clk) #1;
    cs_n = 1'b1;
    ad_in = ~ad_in;
  endtask
endmodule
`default_nettype wire

// file: xrpc_regs_bench.sv
// Self-checking bench for the extended register bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin \
  total_checks++; \
  if ((got) !== (ex)) begin \
    n_errors++; \
    $display("unexpected %s exp %h got %h", nm, ex, got); \
  end \
end

module xrpc_regs_bench;
  localparam int LEAD = 20;
  logic clk = 1'b0, rstn = 1'b0, power_good_signal = 1'b1;
  logic vcc_present = 1'b1, aux_battery_valid = 1'b1, osc_32k = 1'b0;
  logic update_due = 1'b0, update_done = 1'b0;
  logic kick_input_pin_n = 1'b1, ram_clear_input_n = 1'b1;
  logic [31:0] time_now = 32'h0000_0000, alarm_setting = 32'h1234_5678;
  logic [7:0] ad_in, ad_out;
  logic ad_oe, ale, cs_n, rd_n, wr_n, bank_select_bit, update_start;
  logic user_ram_clear, square_wave_pin, aux_battery_enable;
  logic crystal_load_select, pwr_out, pwr_oe, irq_out, irq_oe;
  int n_errors = 0, total_checks = 0;

  // Free-running clock and an unrelated slow oscillator.
  always #2.5 clk = ~clk;
  always #37 osc_32k = ~osc_32k;

  xrpc_host host_inst (.clk(clk), .ad_out(ad_out), .ad_oe(ad_oe),
    .ad_in(ad_in), .ale(ale), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .bank_select_bit(bank_select_bit));

  xrpc_regs #(.UIP_LEAD_CYCLES(LEAD)) xrpc_regs_inst (.clk(clk),
    .rstn(rstn), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
    .ale(ale), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .bank_select_bit(bank_select_bit),
    .power_good_signal(power_good_signal), .vcc_present(vcc_present),
    .aux_battery_valid(aux_battery_valid), .update_due(update_due),
    .update_done(update_done), .update_start(update_start),
    .time_now(time_now), .alarm_setting(alarm_setting),
    .kick_input_pin_n(kick_input_pin_n),
    .ram_clear_input_n(ram_clear_input_n),
    .user_ram_clear(user_ram_clear), .osc_32k(osc_32k),
    .square_wave_pin(square_wave_pin),
    .aux_battery_enable(aux_battery_enable),
    .crystal_load_select(crystal_load_select),
    .power_on_request_pin_n_out(pwr_out),
    .power_on_request_pin_n_oe(pwr_oe),
    .interrupt_request_pin_n_out(irq_out),
    .interrupt_request_pin_n_oe(irq_oe));

  ////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       oe;
    host_inst.acc(1'b1, a, d, q, oe);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] ex);
    logic [7:0] q;
    logic       oe;
    host_inst.acc(1'b0, a, 8'h00, q, oe);
    `CHK($sformatf("oe %h", a), 1'b1, oe)
    `CHK($sformatf("read %h", a), ex, q)
  endtask

  // Verdict; a timeout also lands here.
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic t_uip();
    int i;
    update_due = 1'b1;
    cyc(1);
    update_due = 1'b0;
    rdc(8'h4a, 8'hc0);
    for (i = 0; i < 40 && update_start !== 1'b1; i++) cyc(1);
    `CHK("start", 1'b1, update_start)
    if (i == 40) conclude();
    update_done = 1'b1;
    cyc(1);
    update_done = 1'b0;
    rdc(8'h4a, 8'h80);
  endtask

  task automatic t_sram();
    wr(8'h50, 8'ha5);
    wr(8'h51, 8'hff);
    rdc(8'h51, 8'h1f);
    wr(8'h53, 8'h3c);
    rdc(8'h53, 8'h3c);
    rdc(8'h53, 8'h3c);
    rdc(8'h50, 8'ha5);
    host_inst.bank_select_bit = 1'b0;
    wr(8'h50, 8'h5a);
    host_inst.bank_select_bit = 1'b1;
    rdc(8'h50, 8'ha5);
    power_good_signal = 1'b0;
    wr(8'h53, 8'hc3);
    power_good_signal = 1'b1;
    rdc(8'h53, 8'h3c);
  endtask

  // Burst across the top of the array, which wraps to zero.
  task automatic t_burst();
    wr(8'h4a, 8'h30);
    rdc(8'h4a, 8'hb0);
    wr(8'h50, 8'hff);
    wr(8'h53, 8'h11);
    wr(8'h53, 8'h22);
    rdc(8'h51, 8'h00);
    wr(8'h50, 8'hff);
    wr(8'h51, 8'h1f);
    rdc(8'h53, 8'h11);
    rdc(8'h53, 8'h22);
    rdc(8'h50, 8'h01);
    wr(8'h4a, 8'h00);
  endtask

  task automatic t_stack();
    logic [7:0] q;
    logic       oe;
    wr(8'h4b, 8'h40);
    wr(8'h4a, 8'h00);
    rdc(8'h4e, 8'h4b);
    rdc(8'h4f, 8'h4e);
    wr(8'h4f, 8'h00);
    rdc(8'h4e, 8'h4f);
    host_inst.acc(1'b0, 8'h52, 8'h00, q, oe);
    `CHK("unmapped oe", 1'b0, oe)
  endtask

  task automatic t_power();
    wr(8'h4b, 8'h43);
    wr(8'h4a, 8'h08);
    cyc(2);
    `CHK("pwr_oe", 1'b0, pwr_oe)
    kick_input_pin_n = 1'b0;
    cyc(2);
    kick_input_pin_n = 1'b1;
    cyc(2);
    `CHK("irq_oe", 1'b1, irq_oe)
    `CHK("pwr_oe", 1'b1, pwr_oe)
    rdc(8'h4a, 8'h81);
    wr(8'h4a, 8'h00);
    cyc(2);
    `CHK("irq_oe", 1'b0, irq_oe)
    time_now = alarm_setting;
    cyc(3);
    `CHK("irq_oe", 1'b1, irq_oe)
    rdc(8'h4a, 8'h82);
    time_now = 32'h0000_0000;
    wr(8'h4a, 8'h00);
    rdc(8'h4a, 8'h80);
    wr(8'h4b, 8'h40);
    wr(8'h4a, 8'h03);
    cyc(2);
    `CHK("irq_oe", 1'b0, irq_oe)
    rdc(8'h4a, 8'h83);
    wr(8'h4a, 8'h00);
  endtask

  task automatic t_clear();
    wr(8'h4b, 8'h10);
    ram_clear_input_n = 1'b0;
    cyc(3);
    `CHK("ram_clear", 1'b1, user_ram_clear)
    `CHK("irq_oe", 1'b0, irq_oe)
    ram_clear_input_n = 1'b1;
    rdc(8'h4a, 8'h84);
    wr(8'h4b, 8'h14);
    cyc(2);
    `CHK("irq_oe", 1'b1, irq_oe)
    wr(8'h4a, 8'h00);
    cyc(2);
    `CHK("irq_oe", 1'b0, irq_oe)
    wr(8'h4b, 8'h00);
    ram_clear_input_n = 1'b0;
    cyc(3);
    `CHK("ram_clear", 1'b0, user_ram_clear)
    ram_clear_input_n = 1'b1;
    rdc(8'h4a, 8'h80);
    `CHK("sqw", 1'b0, square_wave_pin)
  endtask

  task automatic t_fail();
    int i;
    wr(8'h4b, 8'ha0);
    cyc(2);
    `CHK("abe", 1'b1, aux_battery_enable)
    `CHK("xtal", 1'b1, crystal_load_select)
    wr(8'h4b, 8'h00);
    vcc_present = 1'b0;
    cyc(3);
    `CHK("pwr_oe", 1'b0, pwr_oe)
    vcc_present = 1'b1;
    cyc(3);
    rdc(8'h4b, 8'h40);
    // Oscillator high for a whole cycle must reach the square wave pin.
    for (i = 0; i < 40 && osc_32k !== 1'b1; i++) cyc(1);
    cyc(1);
    `CHK("sqw on", 1'b1, square_wave_pin)
    rdc(8'h4a, 8'h88);
    wr(8'h4b, 8'h48);
    wr(8'h4a, 8'h00);
    vcc_present = 1'b0;
    cyc(3);
    `CHK("pwr_oe", 1'b1, pwr_oe)
    vcc_present = 1'b1;
    cyc(3);
  endtask

  // Main sequence: reset for four cycles, then each scenario.
  initial begin
    cyc(4);
    rstn = 1'b1;
    cyc(2);
    `CHK("pwr_oe", 1'b1, pwr_oe)
    rdc(8'h4b, 8'h40);
    t_uip();
    t_sram();
    t_burst();
    t_stack();
    t_power();
    t_clear();
    t_fail();
    conclude();
  end
endmodule
`default_nettype wire
